/* File: stepper_axis.sv */
// One axis: ramped step-rate generator with move sequencing and limit stops
`timescale 1ns/10ps
module stepper_axis
   import stepper_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire axis_cfg_t cfg,
   input wire move_cmd_t cmd,
   input wire logic cmdLoad,
   input wire logic start,
   input wire stop_req_t stopReq,
   input wire logic originSwitch,
   input wire logic slowdownSwitch,
   output motor_out_t motorOut,
   output logic [7:0] status
);
   typedef enum logic [1:0] {IDLE, ACCEL, CRUISE, DECEL} phase_t;

   phase_t state_r, state_nxt;
   move_cmd_t pend_r, pend_nxt;
   logic [13:0] rate_r, rate_nxt;
   logic [27:0] acc_r, acc_nxt;
   logic [23:0] left_r, left_nxt;
   logic [23:0] rampSteps_r, rampSteps_nxt;
   logic [31:0] tick_r, tick_nxt;
   logic [7:0] width_r, width_nxt;
   logic halting_r, halting_nxt;
   logic slowing_r, slowing_nxt;
   logic stepOut_r, stepOut_nxt;
   logic dirOut_r, dirOut_nxt;
   logic negDir_r, negDir_nxt;
   logic [7:0] status_r, status_nxt;

   logic pulse;
   logic rampTick;
   logic [13:0] targetRate;
   logic [27:0] accSum;
   logic isHigh, isPreset, isHome;

   always_comb begin
      isHigh = pend_r.kind inside {MOVE_HIGH_CONT, MOVE_HIGH_HOME, MOVE_HIGH_PRESET};
      isPreset = pend_r.kind inside {MOVE_LOW_PRESET, MOVE_HIGH_PRESET};
      isHome = pend_r.kind inside {MOVE_LOW_HOME, MOVE_HIGH_HOME};
      accSum = acc_r + 28'(rate_r);
      pulse = (state_r != IDLE) && (accSum >= PHASE_WRAP);
      rampTick = tick_r >= ACCEL_UNIT_CYCLES * 32'(cfg.accelRate);
      targetRate = cfg.highRate;
      state_nxt = state_r;
      pend_nxt = pend_r;
      rate_nxt = rate_r;
      acc_nxt = pulse ? accSum - PHASE_WRAP : accSum;
      left_nxt = left_r;
      rampSteps_nxt = rampSteps_r;
      tick_nxt = rampTick ? 32'h0 : tick_r + 32'h1;
      halting_nxt = halting_r;
      slowing_nxt = slowing_r;
      negDir_nxt = negDir_r;
      width_nxt = (width_r != 8'h00) ? width_r - 8'h01 : 8'h00;
      if (pulse) begin
         width_nxt = STEP_WIDTH;
         if (isPreset) begin
            left_nxt = left_r - 24'h1;
         end
         if (state_r == ACCEL) begin
            rampSteps_nxt = rampSteps_r + 24'h1;
         end
      end
      if (cmdLoad && state_r == IDLE) begin
         pend_nxt = cmd;
      end
      case (state_r)
         IDLE: begin
            acc_nxt = 28'h0;
            if (start) begin
               // Common start launches every axis selected in axisSelect together
               negDir_nxt = pend_r.negDir;
               rate_nxt = cfg.lowRate;
               left_nxt = pend_r.stepCount;
               rampSteps_nxt = 24'h0;
               halting_nxt = 1'b0;
               slowing_nxt = 1'b0;
               tick_nxt = 32'h0;
               state_nxt = isHigh ? ACCEL : CRUISE;
               if (isPreset && pend_r.stepCount == 24'h0) begin
                  state_nxt = IDLE;
               end
            end
         end
         ACCEL: begin
            if (rampTick) begin
               // Constant rate increment per ramp interval
               rate_nxt = (rate_r < targetRate) ? rate_r + 14'h1 : rate_r;
            end
            if (rate_r >= targetRate) begin
               state_nxt = CRUISE;
            end
            // Preset move turns at the midpoint when the top is never reached
            if (isPreset && (left_r <= rampSteps_r + 24'h1)) begin
               state_nxt = DECEL;
            end
         end
         CRUISE: begin
            if (isPreset && isHigh && left_r <= rampSteps_r + 24'h1) begin
               state_nxt = DECEL;
            end
         end
         DECEL: begin
            if (rampTick && rate_r > cfg.lowRate) begin
               rate_nxt = rate_r - 14'h1;
            end
            if (rate_r <= cfg.lowRate) begin
               rate_nxt = cfg.lowRate;
               state_nxt = halting_r ? IDLE : CRUISE;
            end
         end
         default: state_nxt = IDLE;
      endcase
      if (state_r != IDLE) begin
         if (stopReq.rampedHalt) begin
            halting_nxt = 1'b1;
            state_nxt = DECEL;
         end else if (stopReq.slowdown && isHigh) begin
            slowing_nxt = 1'b1;
            state_nxt = DECEL;
         end
         if (pend_r.kind == MOVE_HIGH_HOME && slowdownSwitch && !slowing_r) begin
            slowing_nxt = 1'b1;
            state_nxt = DECEL;
         end
         if (slowing_r && state_r == CRUISE) begin
            rate_nxt = cfg.lowRate;
         end
         if (isPreset && pulse && left_r == 24'h1) begin
            state_nxt = IDLE;
         end
         if (isHome && originSwitch) begin
            state_nxt = IDLE;
         end
         if (stopReq.stopNow) begin
            state_nxt = IDLE;
         end
      end
      // Only an immediate stop cuts a pulse; other ends let the last step keep its full width
      stepOut_nxt = (width_nxt != 8'h00) && (pulse || stepOut_r)
         && !(stopReq.stopNow && state_r != IDLE);
      dirOut_nxt = negDir_nxt;
      status_nxt = STATUS_RESET;
      status_nxt[BUSY_BIT] = (state_nxt != IDLE) || stepOut_nxt;
      status_nxt[ORIGIN_BIT] = originSwitch;
      status_nxt[SLOWDOWN_BIT] = slowdownSwitch;
      status_nxt[DIR_BIT] = negDir_nxt;
      status_nxt[RAMP_BIT] = (state_nxt == ACCEL) || (state_nxt == DECEL);
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_r <= IDLE;
         pend_r <= '0;
         rate_r <= RATE_RESET;
         acc_r <= 28'h0;
         left_r <= 24'h0;
         rampSteps_r <= 24'h0;
         tick_r <= 32'h0;
         width_r <= 8'h00;
         halting_r <= 1'b0;
         slowing_r <= 1'b0;
         stepOut_r <= 1'b0;
         dirOut_r <= 1'b0;
         negDir_r <= 1'b0;
         status_r <= STATUS_RESET;
      end else begin
         state_r <= state_nxt;
         pend_r <= pend_nxt;
         rate_r <= rate_nxt;
         acc_r <= acc_nxt;
         left_r <= left_nxt;
         rampSteps_r <= rampSteps_nxt;
         tick_r <= tick_nxt;
         width_r <= width_nxt;
         halting_r <= halting_nxt;
         slowing_r <= slowing_nxt;
         stepOut_r <= stepOut_nxt;
         dirOut_r <= dirOut_nxt;
         negDir_r <= negDir_nxt;
         status_r <= status_nxt;
      end
   end

   assign motorOut.stepLine = stepOut_r;
   assign motorOut.dirLine = dirOut_r;
   assign status = status_r;

   a_stop_immediate: assert property (@(posedge clock) disable iff (reset)
      stopReq.stopNow && state_r != IDLE |=> state_r == IDLE)
      else $error("stop did not halt axis");
   a_busy_tracks: assert property (@(posedge clock) disable iff (reset)
      state_r != IDLE |-> status_r[BUSY_BIT])
      else $error("busy low while moving");
   a_origin_stop: assert property (@(posedge clock) disable iff (reset)
      state_r != IDLE && isHome && originSwitch |=> state_r == IDLE)
      else $error("home seek ignored origin");
   a_low_rate_hold: assert property (@(posedge clock) disable iff (reset)
      state_r == CRUISE && !isHigh |-> rate_r == cfg.lowRate)
      else $error("low move off low rate");
   a_ramp_linear: assert property (@(posedge clock) disable iff (reset)
      state_r == ACCEL && $past(state_r) == ACCEL && !$past(rampTick) |-> $stable(rate_r))
      else $error("rate moved outside ramp tick");
   a_halt_ends: assert property (@(posedge clock) disable iff (reset)
      state_r == DECEL && halting_r && rate_r <= cfg.lowRate && !cmdLoad |=> state_r == IDLE)
      else $error("ramped halt did not stop");
   a_slow_keeps: assert property (@(posedge clock) disable iff (reset)
      state_r == DECEL && !halting_r && rate_r <= cfg.lowRate && stopReq == '0 && !originSwitch
      && !isPreset |=> state_r == CRUISE)
      else $error("slowdown did not keep stepping");
   a_idle_quiet: assert property (@(posedge clock) disable iff (reset)
      state_r == IDLE && width_r == 8'h00 |=> !stepOut_r)
      else $error("step while idle");
endmodule

/* File: stepper_pkg.sv */
// Shared constants and carrier types for the three-axis stepping pulse block
package stepper_pkg;
   localparam int NUM_AXES = 3;
   localparam int CLOCK_HZ = 100000000;
   localparam logic [13:0] RATE_MIN = 14'h0001;
   localparam logic [13:0] RATE_MAX = 14'h3ffe;
   localparam logic [9:0] ACCEL_MIN = 10'h002;
   localparam logic [9:0] ACCEL_MAX = 10'h3ff;
   localparam int BUSY_BIT = 6;
   localparam int ORIGIN_BIT = 0;
   localparam int SLOWDOWN_BIT = 1;
   localparam int DIR_BIT = 2;
   localparam int RAMP_BIT = 3;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [7:0] PORT_RESET = 8'h00;
   localparam logic [13:0] RATE_RESET = 14'h0064;
   localparam logic [9:0] ACCEL_RESET = 10'h064;
   // Ramp tick period: one rate step per (ACCEL_UNIT_NS * setting) of time
   localparam int ACCEL_UNIT_NS = 10000;
   localparam int CLOCK_NS = 10;
   localparam logic [31:0] ACCEL_UNIT_CYCLES = 32'(ACCEL_UNIT_NS / CLOCK_NS);
   // Phase accumulator: a step pulse each time the accumulator wraps CLOCK_HZ
   localparam logic [27:0] PHASE_WRAP = 28'(CLOCK_HZ);
   localparam int STEP_WIDTH_CYC = 200;
   localparam logic [7:0] STEP_WIDTH = 8'(STEP_WIDTH_CYC);

   typedef enum logic [2:0] {
      MOVE_LOW_CONT,
      MOVE_HIGH_CONT,
      MOVE_LOW_HOME,
      MOVE_HIGH_HOME,
      MOVE_LOW_PRESET,
      MOVE_HIGH_PRESET
   } move_kind_t;

   typedef struct packed {
      logic [13:0] lowRate;
      logic [13:0] highRate;
      logic [9:0] accelRate;
      logic dualPulseMode;
   } axis_cfg_t;

   typedef struct packed {
      move_kind_t kind;
      logic negDir;
      logic [23:0] stepCount;
   } move_cmd_t;

   typedef struct packed {
      logic slowdown;
      logic rampedHalt;
      logic stopNow;
   } stop_req_t;

   typedef struct packed {
      logic stepLine;
      logic dirLine;
   } motor_out_t;
endpackage

/* File: stepper_pulse_channel_control.sv */
// Three-axis stepping pulse controller top with digital I/O ports
`timescale 1ns/10ps
// How it works
// - Low and high rates span 1 to 16382
// - Ramp setting spans 2 to 1023
// - Step-and-sign mode: direction plus step lines
// - Dual-pulse mode: pulses on one direction line
// - Slowdown ramps to low rate, keeps stepping
// - Ramped halt decelerates to low, then stops
// - Immediate stop ends stepping without ramp
// - Busy flag at status bit 6
// - Low continuous move runs until stopped
// - High continuous move ramps up, runs until stopped
// - Low home seek stops on origin switch
// - High home seek slows on slowdown, stops origin
// - Low preset move issues exact pulse count
// - High preset ramps both ways, exact total count
// - One common start launches selected axes together
// - Two output bytes hold last written value
// - Two input bytes readable at any time
module stepper_pulse_channel_control
   import stepper_pkg::*;
(
   input wire logic clock,
   input wire logic reset,
   input wire logic [2:0] axisSelect,
   input wire logic cfgWrite,
   input wire axis_cfg_t cfgIn,
   input wire logic cmdLoad,
   input wire move_cmd_t cmdIn,
   input wire logic commonStart,
   input wire stop_req_t stopIn,
   input wire logic [2:0] originSwitch,
   input wire logic [2:0] slowdownSwitch,
   output logic [2:0] cfgRejected,
   output logic [2:0] stepOrPosLine,
   output logic [2:0] dirOrNegLine,
   output logic [23:0] statusBytes,
   input wire logic [1:0] outPortWrite,
   input wire logic [7:0] outPortData,
   output logic [7:0] outPort0,
   output logic [7:0] outPort1,
   input wire logic [7:0] inPins0,
   input wire logic [7:0] inPins1,
   output logic [7:0] inPort0,
   output logic [7:0] inPort1
);
   axis_cfg_t cfg_r [NUM_AXES];
   axis_cfg_t cfg_nxt [NUM_AXES];
   logic [2:0] rej_r, rej_nxt;
   logic [2:0] posOut_r, posOut_nxt;
   logic [2:0] negOut_r, negOut_nxt;
   logic [7:0] out0_r, out0_nxt, out1_r, out1_nxt;
   logic [7:0] in0_r, in1_r;
   motor_out_t motor [NUM_AXES];
   logic [7:0] axisStatus [NUM_AXES];
   logic cfgOk;

   always_comb begin
      // Out-of-range settings are refused rather than clipped
      cfgOk = cfgIn.lowRate >= RATE_MIN && cfgIn.lowRate <= RATE_MAX
         && cfgIn.highRate >= RATE_MIN && cfgIn.highRate <= RATE_MAX
         && cfgIn.accelRate >= ACCEL_MIN && cfgIn.accelRate <= ACCEL_MAX;
      out0_nxt = outPortWrite[0] ? outPortData : out0_r;
      out1_nxt = outPortWrite[1] ? outPortData : out1_r;
   end

   genvar g;
   generate
      for (g = 0; g < NUM_AXES; g++) begin : axis
         always_comb begin
            cfg_nxt[g] = cfg_r[g];
            rej_nxt[g] = rej_r[g];
            if (cfgWrite && axisSelect[g]) begin
               rej_nxt[g] = !cfgOk;
               if (cfgOk) begin
                  cfg_nxt[g] = cfgIn;
               end
            end
            if (cfg_r[g].dualPulseMode) begin
               posOut_nxt[g] = motor[g].stepLine && !motor[g].dirLine;
               negOut_nxt[g] = motor[g].stepLine && motor[g].dirLine;
            end else begin
               posOut_nxt[g] = motor[g].stepLine;
               negOut_nxt[g] = motor[g].dirLine;
            end
         end

         always_ff @(posedge clock) begin
            if (reset) begin
               cfg_r[g] <= '{lowRate: RATE_RESET, highRate: RATE_RESET, accelRate: ACCEL_RESET,
                  dualPulseMode: 1'b0};
               rej_r[g] <= 1'b0;
               posOut_r[g] <= 1'b0;
               negOut_r[g] <= 1'b0;
            end else begin
               cfg_r[g] <= cfg_nxt[g];
               rej_r[g] <= rej_nxt[g];
               posOut_r[g] <= posOut_nxt[g];
               negOut_r[g] <= negOut_nxt[g];
            end
         end

         stepper_axis stepper_axis_i (
            .clock(clock),
            .reset(reset),
            .cfg(cfg_r[g]),
            .cmd(cmdIn),
            .cmdLoad(cmdLoad && axisSelect[g]),
            .start(commonStart && axisSelect[g]),
            .stopReq(axisSelect[g] ? stopIn : stop_req_t'(3'h0)),
            .originSwitch(originSwitch[g]),
            .slowdownSwitch(slowdownSwitch[g]),
            .motorOut(motor[g]),
            .status(axisStatus[g])
         );

         assign statusBytes[8*g +: 8] = axisStatus[g];

         a_dual_exclusive: assert property (@(posedge clock) disable iff (reset)
            !(posOut_r[g] && negOut_r[g] && cfg_r[g].dualPulseMode))
            else $error("both pulse lines active");
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (reset) begin
         out0_r <= PORT_RESET;
         out1_r <= PORT_RESET;
         in0_r <= PORT_RESET;
         in1_r <= PORT_RESET;
      end else begin
         out0_r <= out0_nxt;
         out1_r <= out1_nxt;
         in0_r <= inPins0;
         in1_r <= inPins1;
      end
   end

   assign cfgRejected = rej_r;
   assign stepOrPosLine = posOut_r;
   assign dirOrNegLine = negOut_r;
   assign outPort0 = out0_r;
   assign outPort1 = out1_r;
   assign inPort0 = in0_r;
   assign inPort1 = in1_r;

   a_port_hold: assert property (@(posedge clock) disable iff (reset)
      outPortWrite[0] |=> outPort0 == $past(outPortData))
      else $error("output port 0 lost write");
   a_input_follow: assert property (@(posedge clock) disable iff (reset)
      1'b1 |=> inPort1 == $past(inPins1))
      else $error("input port 1 stale");
   a_cfg_range: assert property (@(posedge clock) disable iff (reset)
      cfgWrite && axisSelect[0] && cfgIn.accelRate < ACCEL_MIN |=> cfgRejected[0])
      else $error("bad ramp setting accepted");
endmodule

/* File: motor_partner.sv */
// Behavioural stepping driver stage and limit switches for three axes
`timescale 1ns/10ps
module motor_partner #(
   parameter int ORIGIN_AFTER = 2,
   parameter int SLOW_AFTER = 1
) (
   input wire logic clock,
   input wire logic clear,
   input wire logic [2:0] dualMode,
   input wire logic [2:0] homeArm,
   input wire logic [2:0] stepOrPosLine,
   input wire logic [2:0] dirOrNegLine,
   output logic [2:0] originSwitch,
   output logic [2:0] slowdownSwitch,
   output logic [7:0] posCount [3],
   output logic [7:0] negCount [3]
);
   logic [2:0] posLast_r;
   logic [2:0] negLast_r;
   // Rising edges only, so a line stuck high shows as missing steps
   always_ff @(posedge clock) begin
      posLast_r <= stepOrPosLine;
      negLast_r <= dirOrNegLine;
      for (int g = 0; g < 3; g++) begin
         if (clear) begin
            posCount[g] <= 8'h00;
            negCount[g] <= 8'h00;
         end else begin
            if (stepOrPosLine[g] && !posLast_r[g] && !(dirOrNegLine[g] && !dualMode[g])) begin
               posCount[g] <= posCount[g] + 8'h01;
            end
            if (dualMode[g] ? (dirOrNegLine[g] && !negLast_r[g]) : (stepOrPosLine[g] && !posLast_r[g]
                  && dirOrNegLine[g])) begin
               negCount[g] <= negCount[g] + 8'h01;
            end
         end
      end
   end
   // Switches stay open until the armed axis has travelled far enough
   always_comb begin
      for (int g = 0; g < 3; g++) begin
         originSwitch[g] = homeArm[g] && (32'(posCount[g]) + 32'(negCount[g]) >= ORIGIN_AFTER);
         slowdownSwitch[g] = homeArm[g] && (32'(posCount[g]) + 32'(negCount[g]) >= SLOW_AFTER);
      end
   end
endmodule

/* File: stepper_pulse_channel_control_tb.sv */
// Self-checking bench for the three-axis stepping pulse controller
`timescale 1ns/10ps
module stepper_pulse_channel_control_tb import stepper_pkg::*; ;
   logic clock, reset, cfgWrite, cmdLoad, commonStart, clear;
   logic [2:0] axisSelect, originSwitch, slowdownSwitch, cfgRejected, stepOrPosLine, dirOrNegLine;
   logic [2:0] dualMode, homeArm, busy;
   axis_cfg_t cfgIn;
   move_cmd_t cmdIn;
   stop_req_t stopIn;
   logic [23:0] statusBytes;
   logic [1:0] outPortWrite;
   logic [7:0] outPortData, outPort0, outPort1, inPins0, inPins1, inPort0, inPort1, held;
   logic [7:0] posCount [3];
   logic [7:0] negCount [3];
   int num_errors = 0;
   int checks = 0;
   assign busy = {statusBytes[16 + BUSY_BIT], statusBytes[8 + BUSY_BIT], statusBytes[BUSY_BIT]};
   stepper_pulse_channel_control stepper_pulse_channel_control_i (.clock(clock), .reset(reset),
      .axisSelect(axisSelect), .cfgWrite(cfgWrite), .cfgIn(cfgIn), .cmdLoad(cmdLoad), .cmdIn(cmdIn),
      .commonStart(commonStart), .stopIn(stopIn), .originSwitch(originSwitch), .slowdownSwitch(slowdownSwitch),
      .cfgRejected(cfgRejected), .stepOrPosLine(stepOrPosLine), .dirOrNegLine(dirOrNegLine),
      .statusBytes(statusBytes), .outPortWrite(outPortWrite), .outPortData(outPortData), .outPort0(outPort0),
      .outPort1(outPort1), .inPins0(inPins0), .inPins1(inPins1), .inPort0(inPort0), .inPort1(inPort1));
   motor_partner motor_partner_i (.clock(clock), .clear(clear), .dualMode(dualMode), .homeArm(homeArm),
      .stepOrPosLine(stepOrPosLine), .dirOrNegLine(dirOrNegLine), .originSwitch(originSwitch),
      .slowdownSwitch(slowdownSwitch), .posCount(posCount), .negCount(negCount));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task conclude;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string name, input logic [23:0] seen, input logic [23:0] expv);
      checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, expv, seen);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task cfgTry(input logic [2:0] m, input logic [13:0] lo, input logic [13:0] hi, input logic [9:0] acc,
         input logic dual, input logic [2:0] expRej);
      @(posedge clock);
      axisSelect <= m;
      cfgIn <= '{lo, hi, acc, dual};
      cfgWrite <= 1'b1;
      @(posedge clock);
      cfgWrite <= 1'b0;
      tick(1);
      chk("cfgRejected", 24'(cfgRejected & m), 24'(expRej));
   endtask
   task loadCmd(input logic [2:0] m, input move_kind_t k, input logic neg, input logic [23:0] cnt);
      @(posedge clock);
      axisSelect <= m;
      cmdIn <= '{k, neg, cnt};
      cmdLoad <= 1'b1;
      @(posedge clock);
      cmdLoad <= 1'b0;
   endtask
   task goAll(input logic [2:0] m);
      @(posedge clock);
      axisSelect <= m;
      commonStart <= 1'b1;
      @(posedge clock);
      commonStart <= 1'b0;
      tick(3);
   endtask
   task stopReq(input logic [2:0] m, input stop_req_t s);
      @(posedge clock);
      axisSelect <= m;
      stopIn <= s;
      @(posedge clock);
      stopIn <= '0;
      tick(2);
   endtask
   task waitIdle(input logic [2:0] m, input int limit);
      for (int i = 0; i < limit; i++) begin
         tick(1);
         if ((busy & m) === 3'b000) return;
      end
      chk("busy wait", 24'(busy & m), 24'h0);
      conclude;
   endtask
   task clearCounts;
      @(posedge clock);
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      tick(1);
   endtask
   task test_ports;
      @(posedge clock);
      outPortWrite <= 2'b01;
      outPortData <= 8'h33;
      @(posedge clock);
      outPortWrite <= 2'b10;
      outPortData <= 8'h37;
      @(posedge clock);
      outPortWrite <= 2'b00;
      inPins0 <= 8'ha5;
      inPins1 <= 8'h5a;
      tick(3);
      chk("outPort0", 24'(outPort0), 24'h33);
      chk("outPort1", 24'(outPort1), 24'h37);
      chk("inPort0", 24'(inPort0), 24'ha5);
      chk("inPort1", 24'(inPort1), 24'h5a);
   endtask
   task test_low_preset;
      clearCounts;
      loadCmd(3'b001, MOVE_LOW_PRESET, 1'b1, 24'd3);
      goAll(3'b001);
      chk("busy", 24'(busy), 24'h1);
      chk("dir", 24'(dirOrNegLine[0]), 24'h1);
      waitIdle(3'b001, 30000);
      tick(300);
      chk("neg steps", 24'(negCount[0]), 24'd3);
      chk("pos steps", 24'(posCount[0]), 24'd0);
   endtask
   task test_common_dual;
      clearCounts;
      loadCmd(3'b010, MOVE_LOW_PRESET, 1'b0, 24'd2);
      loadCmd(3'b100, MOVE_HIGH_PRESET, 1'b1, 24'd2);
      tick(20);
      chk("busy before start", 24'(busy), 24'h0);
      goAll(3'b110);
      chk("busy together", 24'(busy), 24'h6);
      waitIdle(3'b110, 20000);
      tick(300);
      chk("axis2 pos", 24'(posCount[1]), 24'd2);
      chk("axis2 neg", 24'(negCount[1]), 24'd0);
      chk("axis3 neg", 24'(negCount[2]), 24'd2);
      chk("axis3 pos", 24'(posCount[2]), 24'd0);
   endtask
   task test_cont_stop;
      clearCounts;
      loadCmd(3'b001, MOVE_LOW_CONT, 1'b0, 24'd0);
      goAll(3'b001);
      tick(7000);
      chk("cont steps", 24'(posCount[0]), 24'd1);
      stopReq(3'b001, '{1'b1, 1'b0, 1'b0});
      chk("busy after slowdown", 24'(busy), 24'h1);
      stopReq(3'b001, '{1'b0, 1'b0, 1'b1});
      chk("busy after stop", 24'(busy), 24'h0);
      chk("step line", 24'(stepOrPosLine), 24'h0);
      // Long enough that a second step would have come without the stop
      tick(6500);
      chk("steps after stop", 24'(posCount[0]), 24'd1);
   endtask
   task test_home;
      clearCounts;
      homeArm <= 3'b001;
      loadCmd(3'b001, MOVE_LOW_HOME, 1'b1, 24'd0);
      goAll(3'b001);
      waitIdle(3'b001, 20000);
      chk("home steps", 24'(negCount[0]), 24'd2);
      chk("origin bit", 24'(statusBytes[ORIGIN_BIT]), 24'h1);
      clearCounts;
      loadCmd(3'b001, MOVE_HIGH_HOME, 1'b1, 24'd0);
      goAll(3'b001);
      chk("home ramp", 24'(statusBytes[RAMP_BIT]), 24'h1);
      waitIdle(3'b001, 20000);
      chk("fast home steps", 24'(negCount[0]), 24'd2);
      chk("slowdown bit", 24'(statusBytes[SLOWDOWN_BIT]), 24'h1);
      homeArm <= 3'b000;
   endtask
   task test_high_halt;
      clearCounts;
      loadCmd(3'b001, MOVE_HIGH_CONT, 1'b0, 24'd0);
      goAll(3'b001);
      chk("accel ramp", 24'(statusBytes[RAMP_BIT]), 24'h1);
      tick(7000);
      chk("high steps", 24'(posCount[0]), 24'd1);
      chk("cruise ramp", 24'(statusBytes[RAMP_BIT]), 24'h0);
      stopReq(3'b001, '{1'b1, 1'b0, 1'b0});
      chk("decel ramp", 24'(statusBytes[RAMP_BIT]), 24'h1);
      tick(6500);
      chk("slowed steps", 24'(posCount[0]), 24'd2);
      chk("slowed ramp", 24'(statusBytes[RAMP_BIT]), 24'h0);
      chk("busy slowed", 24'(busy), 24'h1);
      stopReq(3'b001, '{1'b0, 1'b1, 1'b0});
      waitIdle(3'b001, 7000);
      tick(300);
      held = posCount[0];
      // Spans the slot of the next step that a running axis would make
      tick(5000);
      chk("steps after halt", 24'(posCount[0]), 24'(held));
   endtask
   initial begin
      reset = 1'b1;
      clear = 1'b1;
      {cfgWrite, cmdLoad, commonStart, axisSelect, outPortWrite, outPortData, inPins0, inPins1} = '0;
      cfgIn = '0;
      cmdIn = '0;
      stopIn = '0;
      dualMode = 3'b110;
      homeArm = 3'b000;
      repeat (5) @(posedge clock);
      reset <= 1'b0;
      clear <= 1'b0;
      tick(1);
      chk("status reset", statusBytes, 24'(STATUS_RESET));
      chk("port reset", 24'(outPort0), 24'(PORT_RESET));
      test_ports;
      cfgTry(3'b001, 14'h0000, RATE_MAX, ACCEL_MAX, 1'b0, 3'b001);
      cfgTry(3'b010, RATE_MIN, 14'h3fff, ACCEL_MAX, 1'b0, 3'b010);
      cfgTry(3'b101, RATE_MIN, RATE_MIN, 10'h001, 1'b0, 3'b101);
      // Low rate just under high so the ramps on axis 1 take a few ticks
      cfgTry(3'b001, 14'h3ffc, RATE_MAX, ACCEL_MIN, 1'b0, 3'b000);
      cfgTry(3'b110, RATE_MAX, RATE_MAX, ACCEL_MAX, 1'b1, 3'b000);
      test_low_preset;
      test_common_dual;
      test_cont_stop;
      test_home;
      test_high_halt;
      conclude;
   end
endmodule
